// ==== mtc_pkg.sv ====
// Summary of operation
// RULE_01: Each accepted trigger yields a programmable count of readings, up to 50,000.
// RULE_02: Remote host picks the trigger source: bus, external pulse, or immediate.
// RULE_03: Reset or interface reset selects auto locally and immediate remotely.
// RULE_04: Auto mode, local only, takes readings back to back continuously.
// RULE_05: Each single key press starts one trigger; wait light on while waiting.
// RULE_06: Single key is ignored entirely under remote control.
// RULE_07: External mode: each low-going pulse on the trigger input takes the samples.
// RULE_08: One external trigger arriving during a reading is held, then issued.
// RULE_09: Local single mode also arms the external trigger input.
// RULE_10: Immediate source: trigger always present, measuring starts on entering wait.
// RULE_11: Bus source: trigger command accepted only in the wait state, else refused.
// RULE_12: Group execute trigger counts as bus trigger, only while waiting.
// RULE_13: Triggers outside wait are refused; a trigger in wait starts the sequence.
// RULE_14: Locally the block is always waiting, refusing triggers only while measuring.
// RULE_15: Host enters wait through the measure, read or initiate commands.
// RULE_16: About 20 ms set-up after entering wait; triggers in it are discarded.
// RULE_17: Device clear at any time aborts a measurement and returns to idle.
// RULE_18: Device clear keeps source, sample count, delay and trigger count.
// RULE_19: With limits on, low pulse on pass per good reading, on fail per bad.
// RULE_20: Both limits start at 0, cleared by reset, interface reset, function change.
// RULE_21: Optionally raise a service request on the first out-of-limit reading.
// RULE_22: Beep once, if enabled, on the first failure following a pass.
// RULE_23: Sample count resets to 1 and stays within 1 to 50,000.
// RULE_24: With several samples, the trigger delay precedes every reading.
// RULE_25: Locally one trigger then back; remotely idle after the trigger count.
// RULE_26: Idle after the last trigger's samples; measure light only during a reading.
package mtc_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] MTC_CTRL_OFS = 8'h00;
	localparam logic [7:0] MTC_SAMPLES_OFS = 8'h04;
	localparam logic [7:0] MTC_TRIGCNT_OFS = 8'h08;
	localparam logic [7:0] MTC_DELAY_OFS = 8'h0c;
	localparam logic [7:0] MTC_UPPER_OFS = 8'h10;
	localparam logic [7:0] MTC_LOWER_OFS = 8'h14;
	localparam logic [7:0] MTC_CMD_OFS = 8'h18;
	localparam logic [7:0] MTC_STATUS_OFS = 8'h1c;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MTC_CTRL_REMOTE = 0;
	localparam int MTC_CTRL_SRC_LO = 1;
	localparam int MTC_CTRL_SINGLE = 3;
	localparam int MTC_CTRL_LIMIT = 4;
	localparam int MTC_CTRL_BEEP = 5;
	localparam int MTC_CTRL_SRQ = 6;
	localparam int MTC_CMD_INIT = 0;
	localparam int MTC_CMD_TRG = 1;
	localparam int MTC_CMD_DCLR = 2;
	localparam int MTC_CMD_IRST = 3;
	localparam int MTC_CMD_FUNC = 4;
	localparam int MTC_ST_IGN = 3;
	localparam int MTC_ST_SRQ = 4;
	localparam int MTC_ST_PEND = 5;
	// ----------------------------------------
	// Reset values and limits
	// ----------------------------------------
	localparam logic [15:0] MTC_COUNT_MIN = 16'h0001;
	localparam logic [15:0] MTC_COUNT_MAX = 16'hc350;
	localparam logic [31:0] MTC_DELAY_RESET = 32'h0000_0000;
	localparam logic signed [31:0] MTC_LIMIT_RESET = 32'sh0000_0000;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint MTC_CLK_HZ = 200_000_000;
	localparam longint MTC_SETUP_MS = 20;
	localparam int unsigned MTC_SETUP_CYCLES = int'((MTC_SETUP_MS * MTC_CLK_HZ) / 1000);
	localparam longint MTC_PULSE_NS = 1000;
	localparam logic [15:0] MTC_PULSE_CYCLES = 16'((MTC_PULSE_NS * MTC_CLK_HZ) / 1_000_000_000);
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MTC_SRC_IMM = 2'h0,
		MTC_SRC_BUS = 2'h1,
		MTC_SRC_EXT = 2'h2
	} mtc_src_type;
	typedef enum logic [2:0] {
		MTC_IDLE = 3'h0,
		MTC_SETUP = 3'h1,
		MTC_WAIT = 3'h2,
		MTC_DELAY = 3'h3,
		MTC_MEAS = 3'h4
	} mtc_state_type;
endpackage : mtc_pkg

// ==== mtc_lim_if.sv ====
`timescale 1ns/1ps
interface mtc_lim_if;
	logic valid;
	logic signed [31:0] value;
	logic signed [31:0] upper;
	logic signed [31:0] lower;
	logic pass;
	logic fail;
	modport owner (output valid, output value, output upper, output lower, input pass, input fail);
	modport checker_side (input valid, input value, input upper, input lower, output pass, output fail);
endinterface : mtc_lim_if

// ==== mtc_limit_check.sv ====
`timescale 1ns/1ps
module mtc_limit_check (
	input wire logic clk_i,
	input wire logic reset_i,
	mtc_lim_if.checker_side lim
);
	import mtc_pkg::*;
	// ----------------------------------------
	// Verdict, one cycle after the reading
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			lim.pass <= 1'b0;
			lim.fail <= 1'b0;
		end else begin
			lim.pass <= lim.valid && (lim.value <= lim.upper) && (lim.value >= lim.lower); // RULE_19
			lim.fail <= lim.valid && ((lim.value > lim.upper) || (lim.value < lim.lower)); // RULE_19
		end
	end
endmodule : mtc_limit_check

// ==== mtc_trigger_top.sv ====
`timescale 1ns/1ps
module mtc_trigger_top #(
	parameter int unsigned SETUP_CYCLES_P = mtc_pkg::MTC_SETUP_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic key_single_i,
	input wire logic ext_trig_n_i,
	input wire logic get_i,
	input wire logic reading_valid_i,
	input wire logic signed [31:0] reading_value_i,
	output logic sample_start_o,
	output logic wait_led_o,
	output logic meas_led_o,
	output logic pass_n_o,
	output logic fail_n_o,
	output logic beep_o,
	output logic srq_o
);
	import mtc_pkg::*;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	function automatic logic [15:0] clamp_count(input logic [31:0] v);
		if (v < 32'(MTC_COUNT_MIN))
			clamp_count = MTC_COUNT_MIN;
		else if (v > 32'(MTC_COUNT_MAX))
			clamp_count = MTC_COUNT_MAX;
		else
			clamp_count = v[15:0];
	endfunction : clamp_count

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Bits: 0 single key, 1 external trigger (low true), 2 group execute trigger
	logic [2:0] pin_raw;
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic [2:0] s3_reg;
	logic [2:0] filt_reg;
	logic [2:0] filt_q_reg;
	assign pin_raw = {get_i, ~ext_trig_n_i, key_single_i};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clk_i or posedge reset_i) begin
				if (reset_i) begin
					s1_reg[gi] <= 1'b0;
					s2_reg[gi] <= 1'b0;
					s3_reg[gi] <= 1'b0;
					filt_reg[gi] <= 1'b0;
					filt_q_reg[gi] <= 1'b0;
				end else begin
					s1_reg[gi] <= pin_raw[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
					// Only a level seen twice counts, which rejects one-cycle glitches
					if (s2_reg[gi] == s3_reg[gi])
						filt_reg[gi] <= s3_reg[gi];
					filt_q_reg[gi] <= filt_reg[gi];
				end
			end
		end
	endgenerate

	logic key_edge;
	logic ext_edge;
	logic get_edge;
	assign key_edge = filt_reg[0] & ~filt_q_reg[0];
	assign ext_edge = filt_reg[1] & ~filt_q_reg[1]; // RULE_07
	assign get_edge = filt_reg[2] & ~filt_q_reg[2];

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic remote_reg;
	mtc_src_type src_reg;
	logic single_reg;
	logic limit_en_reg;
	logic beep_en_reg;
	logic srq_en_reg;
	logic [15:0] samples_reg;
	logic [15:0] trig_cnt_reg;
	logic [31:0] delay_reg;
	logic signed [31:0] upper_reg;
	logic signed [31:0] lower_reg;

	logic wr_cmd;
	logic cmd_init;
	logic cmd_trg;
	logic dev_clr;
	logic iface_rst;
	logic func_chg;
	assign wr_cmd = wr_i && hit(addr_i, MTC_CMD_OFS);
	assign cmd_init = wr_cmd && wdata_i[MTC_CMD_INIT];
	assign cmd_trg = wr_cmd && wdata_i[MTC_CMD_TRG];
	assign dev_clr = wr_cmd && wdata_i[MTC_CMD_DCLR];
	assign iface_rst = wr_cmd && wdata_i[MTC_CMD_IRST];
	assign func_chg = wr_cmd && wdata_i[MTC_CMD_FUNC];

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			remote_reg <= 1'b0;
			src_reg <= MTC_SRC_IMM; // RULE_03
			single_reg <= 1'b0; // RULE_03
			limit_en_reg <= 1'b0;
			beep_en_reg <= 1'b0;
			srq_en_reg <= 1'b0;
			samples_reg <= MTC_COUNT_MIN; // RULE_23
			trig_cnt_reg <= MTC_COUNT_MIN;
			delay_reg <= MTC_DELAY_RESET;
		end else if (iface_rst) begin
			src_reg <= MTC_SRC_IMM; // RULE_03
			single_reg <= 1'b0; // RULE_03
			samples_reg <= MTC_COUNT_MIN; // RULE_23
			trig_cnt_reg <= MTC_COUNT_MIN;
			delay_reg <= MTC_DELAY_RESET;
		end else if (wr_i) begin
			// Device clear touches none of these
			if (hit(addr_i, MTC_CTRL_OFS)) begin // RULE_18
				remote_reg <= wdata_i[MTC_CTRL_REMOTE];
				src_reg <= mtc_src_type'(wdata_i[MTC_CTRL_SRC_LO +: 2]); // RULE_02
				single_reg <= wdata_i[MTC_CTRL_SINGLE];
				limit_en_reg <= wdata_i[MTC_CTRL_LIMIT];
				beep_en_reg <= wdata_i[MTC_CTRL_BEEP];
				srq_en_reg <= wdata_i[MTC_CTRL_SRQ];
			end
			if (hit(addr_i, MTC_SAMPLES_OFS))
				samples_reg <= clamp_count(wdata_i); // RULE_23
			if (hit(addr_i, MTC_TRIGCNT_OFS))
				trig_cnt_reg <= clamp_count(wdata_i);
			if (hit(addr_i, MTC_DELAY_OFS))
				delay_reg <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			upper_reg <= MTC_LIMIT_RESET; // RULE_20
			lower_reg <= MTC_LIMIT_RESET; // RULE_20
		end else if (iface_rst || func_chg) begin
			upper_reg <= MTC_LIMIT_RESET; // RULE_20
			lower_reg <= MTC_LIMIT_RESET; // RULE_20
		end else if (wr_i) begin
			if (hit(addr_i, MTC_UPPER_OFS))
				upper_reg <= wdata_i;
			if (hit(addr_i, MTC_LOWER_OFS))
				lower_reg <= wdata_i;
		end
	end

	// ----------------------------------------
	// Trigger qualification
	// ----------------------------------------
	mtc_state_type state_reg;
	logic remote_q_reg;
	logic ext_pend_reg;
	logic abort;
	logic ext_armed;
	logic ext_hit;
	logic bus_hit;
	logic trig_now;
	logic consume;
	logic bus_refused;

	assign abort = dev_clr || iface_rst || (remote_reg != remote_q_reg); // RULE_17
	assign ext_armed = remote_reg ? (src_reg == MTC_SRC_EXT) : single_reg; // RULE_09
	assign ext_hit = ext_pend_reg || (ext_edge && ext_armed); // RULE_07
	assign bus_hit = remote_reg && (src_reg == MTC_SRC_BUS) && (cmd_trg || get_edge); // RULE_11 RULE_12

	always_comb begin
		trig_now = 1'b0;
		if (remote_reg) begin
			case (src_reg)
				MTC_SRC_BUS: trig_now = bus_hit;
				MTC_SRC_EXT: trig_now = ext_hit;
				default: trig_now = 1'b1; // RULE_10
			endcase
		end else begin
			// Key only counts locally
			trig_now = single_reg ? (key_edge || ext_hit) : 1'b1; // RULE_04 RULE_05 RULE_06
		end
	end

	assign consume = (state_reg == MTC_WAIT) && trig_now && !abort; // RULE_13
	assign bus_refused = bus_hit && (state_reg != MTC_WAIT); // RULE_11 RULE_12 RULE_13

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			ext_pend_reg <= 1'b0;
		else if (abort || !ext_armed || state_reg == MTC_IDLE || state_reg == MTC_SETUP)
			ext_pend_reg <= 1'b0; // RULE_16
		else if (consume)
			// A fresh edge with one already held keeps one pending
			ext_pend_reg <= ext_pend_reg && ext_edge; // RULE_08
		else if (state_reg != MTC_WAIT)
			ext_pend_reg <= ext_hit; // RULE_08
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	logic [31:0] setup_cnt_reg;
	logic [31:0] dly_cnt_reg;
	logic [15:0] samp_left_reg;
	logic [15:0] trig_done_reg;
	logic start_next;

	assign start_next = (state_reg == MTC_DELAY) && (dly_cnt_reg == 32'h0) && !abort;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			remote_q_reg <= 1'b0;
		else
			remote_q_reg <= remote_reg;
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= MTC_IDLE;
			setup_cnt_reg <= 32'h0;
			dly_cnt_reg <= 32'h0;
			samp_left_reg <= 16'h0;
			trig_done_reg <= 16'h0;
		end else if (abort) begin
			state_reg <= MTC_IDLE; // RULE_17
			trig_done_reg <= 16'h0;
		end else begin
			case (state_reg)
				MTC_IDLE: begin
					if (!remote_reg)
						state_reg <= MTC_WAIT; // RULE_14
					else if (cmd_init) begin
						state_reg <= MTC_SETUP; // RULE_15
						setup_cnt_reg <= SETUP_CYCLES_P - 32'h1;
					end
				end
				MTC_SETUP: begin
					if (setup_cnt_reg == 32'h0)
						state_reg <= MTC_WAIT; // RULE_16
					else
						setup_cnt_reg <= setup_cnt_reg - 32'h1;
				end
				MTC_WAIT: begin
					if (consume) begin
						state_reg <= MTC_DELAY;
						samp_left_reg <= samples_reg; // RULE_01
						dly_cnt_reg <= delay_reg;
					end
				end
				MTC_DELAY: begin
					if (dly_cnt_reg == 32'h0)
						state_reg <= MTC_MEAS;
					else
						dly_cnt_reg <= dly_cnt_reg - 32'h1;
				end
				MTC_MEAS: begin
					if (reading_valid_i) begin
						if (samp_left_reg > 16'h1) begin
							samp_left_reg <= samp_left_reg - 16'h1; // RULE_01
							dly_cnt_reg <= delay_reg; // RULE_24
							state_reg <= MTC_DELAY;
						end else if (remote_reg && (trig_done_reg + 16'h1 >= trig_cnt_reg)) begin
							trig_done_reg <= 16'h0;
							state_reg <= MTC_IDLE; // RULE_25 RULE_26
						end else begin
							// Local operation ignores the trigger count
							trig_done_reg <= remote_reg ? trig_done_reg + 16'h1 : 16'h0;
							state_reg <= MTC_WAIT; // RULE_25
						end
					end
				end
				default: state_reg <= MTC_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Indicators and sample strobe
	// ----------------------------------------
	logic waits_for_event;
	assign waits_for_event = remote_reg ? (src_reg == MTC_SRC_BUS || src_reg == MTC_SRC_EXT) : single_reg;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sample_start_o <= 1'b0;
			wait_led_o <= 1'b0;
			meas_led_o <= 1'b0;
		end else begin
			sample_start_o <= start_next;
			wait_led_o <= (state_reg == MTC_WAIT) && waits_for_event && !consume; // RULE_05
			meas_led_o <= (state_reg == MTC_MEAS) && !(reading_valid_i || abort); // RULE_26
		end
	end

	// ----------------------------------------
	// Limit test
	// ----------------------------------------
	mtc_lim_if lim_bus ();
	assign lim_bus.valid = limit_en_reg && reading_valid_i && (state_reg == MTC_MEAS) && !abort;
	assign lim_bus.value = reading_value_i;
	assign lim_bus.upper = upper_reg;
	assign lim_bus.lower = lower_reg;

	mtc_limit_check u_check (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.lim(lim_bus.checker_side)
	);

	logic [15:0] pass_cnt_reg;
	logic [15:0] fail_cnt_reg;
	logic last_pass_reg;
	logic fail_seen_reg;
	logic srq_clr;
	logic ign_clr;
	logic trig_ign_reg;
	assign srq_clr = wr_i && hit(addr_i, MTC_STATUS_OFS) && wdata_i[MTC_ST_SRQ];
	assign ign_clr = wr_i && hit(addr_i, MTC_STATUS_OFS) && wdata_i[MTC_ST_IGN];

	// Pulses are stretched so slow external gear can catch them
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pass_cnt_reg <= 16'h0;
			fail_cnt_reg <= 16'h0;
			pass_n_o <= 1'b1;
			fail_n_o <= 1'b1;
		end else begin
			pass_cnt_reg <= lim_bus.pass ? MTC_PULSE_CYCLES : (pass_cnt_reg != 16'h0 ? pass_cnt_reg - 16'h1 : 16'h0);
			fail_cnt_reg <= lim_bus.fail ? MTC_PULSE_CYCLES : (fail_cnt_reg != 16'h0 ? fail_cnt_reg - 16'h1 : 16'h0);
			pass_n_o <= !(lim_bus.pass || pass_cnt_reg > 16'h1); // RULE_19
			fail_n_o <= !(lim_bus.fail || fail_cnt_reg > 16'h1); // RULE_19
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			last_pass_reg <= 1'b0;
			beep_o <= 1'b0;
		end else begin
			if (lim_bus.pass)
				last_pass_reg <= 1'b1;
			else if (lim_bus.fail)
				last_pass_reg <= 1'b0;
			beep_o <= lim_bus.fail && last_pass_reg && beep_en_reg; // RULE_22
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			fail_seen_reg <= 1'b0;
			srq_o <= 1'b0;
			trig_ign_reg <= 1'b0;
		end else begin
			if (lim_bus.fail)
				fail_seen_reg <= 1'b1;
			else if (srq_clr || iface_rst)
				fail_seen_reg <= 1'b0;
			if (lim_bus.fail && !fail_seen_reg && srq_en_reg)
				srq_o <= 1'b1; // RULE_21
			else if (srq_clr || iface_rst)
				srq_o <= 1'b0;
			if (bus_refused)
				trig_ign_reg <= 1'b1; // RULE_11
			else if (ign_clr)
				trig_ign_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			rdata_o <= 32'h0;
		else if (rd_i) begin
			case (addr_i)
				MTC_CTRL_OFS: rdata_o <= {25'h0, srq_en_reg, beep_en_reg, limit_en_reg, single_reg, src_reg, remote_reg};
				MTC_SAMPLES_OFS: rdata_o <= {16'h0, samples_reg};
				MTC_TRIGCNT_OFS: rdata_o <= {16'h0, trig_cnt_reg};
				MTC_DELAY_OFS: rdata_o <= delay_reg;
				MTC_UPPER_OFS: rdata_o <= upper_reg;
				MTC_LOWER_OFS: rdata_o <= lower_reg;
				MTC_STATUS_OFS: rdata_o <= {26'h0, ext_pend_reg, srq_o, trig_ign_reg, state_reg};
				default: rdata_o <= 32'h0;
			endcase
		end
	end
endmodule : mtc_trigger_top

// ==== mtc_trigger_sva.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module mtc_trigger_sva
	import mtc_pkg::*;
#(
	parameter int unsigned SETUP_CYCLES_P = 8
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic reading_valid_i,
	input wire logic sample_start_o,
	input wire logic wait_led_o,
	input wire logic meas_led_o,
	input wire logic pass_n_o,
	input wire logic fail_n_o,
	input wire logic beep_o,
	input wire logic srq_o
);
	logic [15:0] pass_lo_reg, fail_lo_reg;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	// Low-time counters
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pass_lo_reg <= 16'h0000;
			fail_lo_reg <= 16'h0000;
		end else begin
			pass_lo_reg <= pass_n_o ? 16'h0000 : pass_lo_reg + 16'h0001;
			fail_lo_reg <= fail_n_o ? 16'h0000 : fail_lo_reg + 16'h0001;
		end
	end
	property p_start_one;
		sample_start_o |=> !sample_start_o;
	endproperty
	a_start_one: assert property (p_start_one) else $error("start pulse too long");
	property p_meas_led;
		sample_start_o |=> meas_led_o;
	endproperty
	a_meas_led: assert property (p_meas_led) else $error("measure light late");
	property p_pass_width;
		$rose(pass_n_o) |-> pass_lo_reg == MTC_PULSE_CYCLES;
	endproperty
	a_pass_width: assert property (p_pass_width) else $error("pass pulse width");
	property p_fail_width;
		$rose(fail_n_o) |-> fail_lo_reg == MTC_PULSE_CYCLES;
	endproperty
	a_fail_width: assert property (p_fail_width) else $error("fail pulse width");
	property p_cause;
		($fell(pass_n_o) || $fell(fail_n_o)) |-> $past(reading_valid_i, 2);
	endproperty
	a_cause: assert property (p_cause) else $error("limit pulse without reading");
	property p_beep;
		beep_o |-> !fail_n_o ##1 !beep_o;
	endproperty
	a_beep: assert property (p_beep) else $error("beep without failure");
	property p_samples;
		rd_i && addr_i == MTC_SAMPLES_OFS |=> rdata_o >= 32'(MTC_COUNT_MIN) && rdata_o <= 32'(MTC_COUNT_MAX);
	endproperty
	a_samples: assert property (p_samples) else $error("sample count out of range");
	property p_srq;
		srq_o && !wr_i |=> srq_o;
	endproperty
	a_srq: assert property (p_srq) else $error("service request dropped");
	property p_wait;
		wait_led_o |-> !meas_led_o;
	endproperty
	a_wait: assert property (p_wait) else $error("waiting while measuring");
	c_pass: cover property ($fell(pass_n_o));
	c_fail: cover property ($fell(fail_n_o));
	c_beep: cover property (beep_o);
endmodule : mtc_trigger_sva

// ==== mtc_meas_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Reading path model
// ----------------------------------------
module mtc_meas_model (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic sample_start_i,
	input wire logic ext_req_i,
	input wire logic [7:0] lat_i,
	input wire logic signed [31:0] value_i,
	output logic reading_valid_o,
	output logic signed [31:0] reading_value_o,
	output logic ext_trig_n_o
);
	logic busy_reg;
	logic [7:0] wait_reg;
	logic [3:0] ext_reg;
	// Bench sets the latency
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			busy_reg <= 1'b0;
			wait_reg <= 8'h00;
		end else if (sample_start_i) begin
			busy_reg <= 1'b1;
			wait_reg <= lat_i;
		end else if (busy_reg) begin
			busy_reg <= wait_reg != 8'h00;
			wait_reg <= wait_reg - 8'h01;
		end
	end
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			ext_reg <= 4'h0;
		else if (ext_req_i)
			ext_reg <= 4'h8;
		else if (ext_reg != 4'h0)
			ext_reg <= ext_reg - 4'h1;
	end
	assign ext_trig_n_o = ext_reg == 4'h0;
	assign reading_valid_o = busy_reg && wait_reg == 8'h00;
	// Junk outside the valid cycle
	assign reading_value_o = reading_valid_o ? value_i : ~value_i;
endmodule : mtc_meas_model

// ==== mtc_trigger_top_tb.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module mtc_trigger_top_tb;
	import mtc_pkg::*;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic key_i = 1'b0;
	logic get_i = 1'b0;
	logic ext_req = 1'b0;
	logic [7:0] lat = 8'h03;
	logic signed [31:0] value = 32'sh0;
	logic signed [31:0] vals [4] = '{32'sd100, 32'sd101, -32'sd101, -32'sd100};
	logic [31:0] rdata_o;
	logic signed [31:0] rvalue;
	logic ext_n, rvalid, sample_start_o, wait_led_o, meas_led_o, pass_n_o, fail_n_o, beep_o, srq_o;
	logic pass_q = 1'b1, fail_q = 1'b1;
	int err_total = 0, checks = 0;
	int n_start, n_pass, n_fail, n_beep, cyc, t_last, gap, g0, d, i;
	always #2.5 clk_i = ~clk_i;
	mtc_trigger_top #(.SETUP_CYCLES_P(8)) mtc_trigger_top_inst (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .key_single_i(key_i), .ext_trig_n_i(ext_n),
		.get_i(get_i), .reading_valid_i(rvalid), .reading_value_i(rvalue), .sample_start_o(sample_start_o),
		.wait_led_o(wait_led_o), .meas_led_o(meas_led_o), .pass_n_o(pass_n_o), .fail_n_o(fail_n_o),
		.beep_o(beep_o), .srq_o(srq_o));
	mtc_meas_model mtc_meas_model_inst (.clk_i(clk_i), .reset_i(reset_i), .sample_start_i(sample_start_o),
		.ext_req_i(ext_req), .lat_i(lat), .value_i(value), .reading_valid_o(rvalid), .reading_value_o(rvalue),
		.ext_trig_n_o(ext_n));
	// Pre-edge values
	always @(posedge clk_i) begin
		cyc++;
		if (sample_start_o === 1'b1) begin
			gap = cyc - t_last;
			t_last = cyc;
			n_start++;
		end
		if (pass_q === 1'b1 && pass_n_o === 1'b0) n_pass++;
		if (fail_q === 1'b1 && fail_n_o === 1'b0) n_fail++;
		if (beep_o === 1'b1) n_beep++;
		pass_q = pass_n_o;
		fail_q = fail_n_o;
	end
	task automatic print_verdict();
		if (err_total == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic cmd(input int b);
		wr(MTC_CMD_OFS, 32'h1 << b);
	endtask : cmd
	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(name, rdata_o & m, exp);
	endtask : rchk
	// Held well past the pin filter
	task automatic press(input bit use_get);
		@(posedge clk_i);
		get_i <= use_get;
		key_i <= !use_get;
		repeat (8) @(posedge clk_i);
		get_i <= 1'b0;
		key_i <= 1'b0;
	endtask : press
	task automatic ext_pulse();
		@(posedge clk_i);
		ext_req <= 1'b1;
		@(posedge clk_i);
		ext_req <= 1'b0;
	endtask : ext_pulse
	task automatic wait_starts(input int n);
		for (int k = 0; k < 3000 && n_start < n; k++) @(posedge clk_i);
		if (n_start < n) begin
			err_total++;
			print_verdict();
		end
	endtask : wait_starts
	initial begin
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		rchk("ctrl", MTC_CTRL_OFS, 32'h7f, 32'h0);
		rchk("samples", MTC_SAMPLES_OFS, '1, 32'h1);
		rchk("trigcnt", MTC_TRIGCNT_OFS, '1, 32'h1);
		rchk("upper", MTC_UPPER_OFS, '1, 32'h0);
		rchk("lower", MTC_LOWER_OFS, '1, 32'h0);
		rchk("unmapped", 8'h20, '1, 32'h0);
		n_start = 0;
		repeat (100) @(posedge clk_i);
		chk("auto", 32'(n_start > 5), 32'h1);
		wr(MTC_CTRL_OFS, 32'h1);
		repeat (20) @(posedge clk_i);
		wr(MTC_SAMPLES_OFS, 32'h0);
		rchk("smp_lo", MTC_SAMPLES_OFS, '1, 32'h1);
		wr(MTC_SAMPLES_OFS, 32'h0000ea60);
		rchk("smp_hi", MTC_SAMPLES_OFS, '1, 32'h0000c350);
		wr(MTC_SAMPLES_OFS, 32'h3);
		for (d = 0; d < 2; d++) begin
			wr(MTC_DELAY_OFS, 32'(d * 5));
			n_start = 0;
			cmd(MTC_CMD_INIT);
			wait_starts(3);
			if (d == 0) g0 = gap;
			repeat (30) @(posedge clk_i);
			chk("burst", 32'(n_start), 32'h3);
			rchk("idle", MTC_STATUS_OFS, 32'h7, 32'h0);
		end
		chk("gap", 32'(gap - g0), 32'h5);
		wr(MTC_SAMPLES_OFS, 32'h1);
		wr(MTC_DELAY_OFS, 32'h0);
		wr(MTC_CTRL_OFS, 32'h3);
		n_start = 0;
		cmd(MTC_CMD_TRG);
		rchk("trg_idle", MTC_STATUS_OFS, 32'h8, 32'h8);
		cmd(MTC_CMD_INIT);
		cmd(MTC_CMD_TRG);
		repeat (12) @(posedge clk_i);
		rchk("wait", MTC_STATUS_OFS, 32'h7, 32'h2);
		chk("wait_led", wait_led_o, 32'h1);
		wr(MTC_STATUS_OFS, 32'h8);
		press(1'b0);
		repeat (10) @(posedge clk_i);
		chk("key_remote", 32'(n_start), 32'h0);
		press(1'b1);
		wait_starts(1);
		repeat (20) @(posedge clk_i);
		rchk("bus_done", MTC_STATUS_OFS, 32'h7, 32'h0);
		press(1'b1);
		repeat (10) @(posedge clk_i);
		rchk("get_idle", MTC_STATUS_OFS, 32'h8, 32'h8);
		chk("get_refused", 32'(n_start), 32'h1);
		wr(MTC_CTRL_OFS, 32'h5);
		wr(MTC_TRIGCNT_OFS, 32'h2);
		wr(MTC_STATUS_OFS, 32'h8);
		lat <= 8'd40;
		n_start = 0;
		cmd(MTC_CMD_INIT);
		repeat (12) @(posedge clk_i);
		ext_pulse();
		wait_starts(1);
		repeat (10) @(posedge clk_i);
		ext_pulse();
		repeat (12) @(posedge clk_i);
		rchk("held", MTC_STATUS_OFS, 32'h28, 32'h20);
		wait_starts(2);
		repeat (60) @(posedge clk_i);
		rchk("ext_done", MTC_STATUS_OFS, 32'h7, 32'h0);
		cmd(MTC_CMD_INIT);
		repeat (12) @(posedge clk_i);
		ext_pulse();
		wait_starts(3);
		cmd(MTC_CMD_DCLR);
		rchk("dclr", MTC_STATUS_OFS, 32'h7, 32'h0);
		chk("dclr_led", meas_led_o, 32'h0);
		rchk("dclr_ctrl", MTC_CTRL_OFS, 32'h7f, 32'h5);
		rchk("dclr_cnt", MTC_TRIGCNT_OFS, '1, 32'h2);
		lat <= 8'd3;
		wr(MTC_CTRL_OFS, 32'h71);
		wr(MTC_TRIGCNT_OFS, 32'h1);
		wr(MTC_UPPER_OFS, 32'd100);
		wr(MTC_LOWER_OFS, -32'sd100);
		n_pass = 0;
		n_fail = 0;
		n_beep = 0;
		for (i = 0; i < 4; i++) begin
			value <= vals[i];
			cmd(MTC_CMD_INIT);
			repeat (260) @(posedge clk_i);
		end
		chk("pass_cnt", 32'(n_pass), 32'h2);
		chk("fail_cnt", 32'(n_fail), 32'h2);
		chk("beep_cnt", 32'(n_beep), 32'h1);
		chk("srq", srq_o, 32'h1);
		cmd(MTC_CMD_FUNC);
		rchk("upper_clr", MTC_UPPER_OFS, '1, 32'h0);
		rchk("lower_clr", MTC_LOWER_OFS, '1, 32'h0);
		wr(MTC_SAMPLES_OFS, 32'h7);
		cmd(MTC_CMD_IRST);
		rchk("irst_src", MTC_CTRL_OFS, 32'h6, 32'h0);
		rchk("irst_smp", MTC_SAMPLES_OFS, '1, 32'h1);
		wr(MTC_CTRL_OFS, 32'h8);
		repeat (10) @(posedge clk_i);
		chk("single_wait", wait_led_o, 32'h1);
		n_start = 0;
		press(1'b0);
		repeat (20) @(posedge clk_i);
		chk("key_start", 32'(n_start), 32'h1);
		ext_pulse();
		repeat (20) @(posedge clk_i);
		chk("ext_start", 32'(n_start), 32'h2);
		print_verdict();
	end
endmodule : mtc_trigger_top_tb
bind mtc_trigger_top mtc_trigger_sva #(.SETUP_CYCLES_P(SETUP_CYCLES_P)) mtc_trigger_sva_inst (.clk_i(clk_i),
	.reset_i(reset_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .reading_valid_i(reading_valid_i),
	.sample_start_o(sample_start_o), .wait_led_o(wait_led_o), .meas_led_o(meas_led_o), .pass_n_o(pass_n_o),
	.fail_n_o(fail_n_o), .beep_o(beep_o), .srq_o(srq_o));
